//--- verilog/pwr_seq_pkg.sv
// constants for the serdes power-down and clock-stop sequencer
package pwr_seq_pkg;
  // pixel clock cycles between relock and link enable
  localparam int unsigned RELOCK_CYCLES = 4096;
  // cycles the link output enable runs before data may flow (calibration)
  localparam int unsigned CAL_CYCLES    = 16;
  // width of the parallel pixel data bus
  localparam int unsigned PIX_W         = 18;
  // pixel clock edges without which lock is taken as lost
  localparam int unsigned LOCK_LOSS_CYC = 8;
  // reset values
  localparam logic        PD_OUT_RST    = 1'b0;
endpackage

//--- verilog/serdes_power_down_clock_stop.sv
// power-up, power-down and clock-stop sequencing for the serdes
// Operation
// - deserializer outputs enabled, zero until data valid
// - low power-down at power-up keeps device down
// - power-down input acts as logic reset
// - power-down switches off all lane currents
// - power-down drives role-specific outputs low
// - lock loss drives power-down output low
// - clock return powers up, relocks first
// - count cycles after relock, enable link
// - serializer data only after enable and calibration
// - role pin swaps the serial lanes
// - role pin reorders parallel bus pins
// - serializer power-down output follows pixel clock
// - high role pin means serializer, drivers on
// - serial clock is six times pixel clock
module serdes_power_down_clock_stop
  import pwr_seq_pkg::*;
#(
  parameter int unsigned RELOCK_COUNT = RELOCK_CYCLES,
  parameter int unsigned PIX_WIDTH    = PIX_W
) (
  // clock, reset, enable
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  input  wire logic                 clk_en,
  // pins from outside the clock domain
  input  wire logic                 power_down_n,
  input  wire logic                 serializer_role,
  input  wire logic                 pixel_clock_in,
  // pll status from the analog macro (same domain)
  input  wire logic                 pll_locked,
  // deserializer side: decoded data from the receive path
  input  wire logic                 rx_data_valid,
  input  wire logic [PIX_WIDTH-1:0] rx_pixel_data,
  input  wire logic                 rx_vsync,
  input  wire logic                 rx_hsync,
  input  wire logic                 rx_de,
  input  wire logic                 rx_parity_err,
  input  wire logic                 rx_pixel_clock,
  // serializer power-down output
  output logic                      power_down_out_n,
  // analog enables
  output logic                      pll_enable,
  output logic                      pll_mult_six,
  output logic                      link_drive_en,
  output logic                      link_recv_en,
  output logic                      lane_current_en,
  output logic                      lane_swap,
  output logic                      parallel_reorder,
  output logic                      data_transfer_ok,
  // deserializer parallel outputs
  output logic [PIX_WIDTH-1:0]      pixel_data_out,
  output logic                      pixel_clock_out,
  output logic                      vertical_sync,
  output logic                      horizontal_sync,
  output logic                      data_valid_strobe,
  output logic                      parity_error_pulse,
  output logic                      parallel_out_en
);

  // sequencer states
  typedef enum logic [2:0] {
    ST_DOWN, ST_LOCK, ST_COUNT, ST_CAL, ST_RUN
  } seq_state_t;

  // one counter serves both phases, so size it for the longer one
  localparam int unsigned LONGEST =
    (RELOCK_COUNT > CAL_CYCLES) ? RELOCK_COUNT : CAL_CYCLES;
  localparam int unsigned CW = $clog2(LONGEST + 1);

  // synchroniser flops; first stage read only by the second
  logic [1:0] pd_sync_q;     // power-down pin
  logic [1:0] role_sync_q;   // role select pin
  logic [1:0] pclk_sync_q;   // pixel clock pin
  logic       pclk_prev_q;   // for rising edge detect
  logic       pd_ok;         // synchronised power-down high
  logic       role_ser;      // synchronised serializer role
  logic       pclk_rise;     // pixel clock rising edge
  seq_state_t state_q;       // sequencer state
  logic [CW-1:0] cnt_q;      // relock / calibration counter
  logic       running;       // link fully up

  // true when the counter sits on the last cycle of a phase
  function automatic logic cnt_last(input logic [CW-1:0] cnt,
                                    input int unsigned   total);
    cnt_last = (cnt == CW'(total - 1));
  endfunction

  // bring the pins into the ref_clk domain
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pd_sync_q   <= 2'h0;
      role_sync_q <= 2'h0;
      pclk_sync_q <= 2'h0;
      pclk_prev_q <= 1'b0;
    end else if (clk_en) begin
      pd_sync_q   <= {pd_sync_q[0], power_down_n};
      role_sync_q <= {role_sync_q[0], serializer_role};
      pclk_sync_q <= {pclk_sync_q[0], pixel_clock_in};
      pclk_prev_q <= pclk_sync_q[1];
    end
  end

  assign pd_ok     = pd_sync_q[1];
  assign role_ser  = role_sync_q[1];
  // only the rising edge matters to the link
  assign pclk_rise = pclk_sync_q[1] & ~pclk_prev_q;

  // sequencer: pd low (or low at power-up) forces the down state
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_DOWN;
      cnt_q   <= '0;
    end else if (clk_en) begin
      if (!pd_ok) begin
        // stays down while pin is low
        state_q <= ST_DOWN;
        cnt_q   <= '0;
      end else begin
        case (state_q)
          ST_DOWN: begin
            // deserializer needs no pll; go straight to run
            state_q <= role_ser ? ST_LOCK : ST_RUN;
            cnt_q   <= '0;
          end
          ST_LOCK: begin
            // wait for relock before anything else
            if (pll_locked) begin
              state_q <= ST_COUNT;
            end
            cnt_q <= '0;
          end
          ST_COUNT: begin
            if (!pll_locked) begin
              state_q <= ST_LOCK;
              cnt_q   <= '0;
            end else if (pclk_rise) begin
              if (cnt_last(cnt_q, RELOCK_COUNT)) begin
                state_q <= ST_CAL;
                cnt_q   <= '0;
              end else begin
                cnt_q <= cnt_q + 1'b1;
              end
            end
          end
          ST_CAL: begin
            if (!pll_locked) begin
              state_q <= ST_LOCK;
              cnt_q   <= '0;
            end else if (pclk_rise) begin
              if (cnt_last(cnt_q, CAL_CYCLES)) begin
                state_q <= ST_RUN;
                cnt_q   <= '0;
              end else begin
                cnt_q <= cnt_q + 1'b1;
              end
            end
          end
          ST_RUN: begin
            if (role_ser && !pll_locked) begin
              state_q <= ST_LOCK;
            end
            cnt_q <= '0;
          end
          default: begin
            state_q <= ST_DOWN;
            cnt_q   <= '0;
          end
        endcase
      end
    end
  end

  assign running = (state_q == ST_RUN);

  // analog controls decoded from state and role
  always_comb begin
    lane_current_en  = pd_ok && (state_q != ST_DOWN);
    link_drive_en    = role_ser && (state_q == ST_CAL || running);
    link_recv_en     = !role_ser && lane_current_en;
    // pll multiplies by six in serializer role
    pll_enable       = role_ser && lane_current_en;
    pll_mult_six     = role_ser;
    lane_swap        = !role_ser;
    parallel_reorder = !role_ser;
    data_transfer_ok = running;
    parallel_out_en  = !role_ser && pd_ok;
  end

  // power-down output low on lock loss
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      power_down_out_n <= PD_OUT_RST;
    end else if (clk_en) begin
      power_down_out_n <= pd_ok && role_ser && pll_locked &&
                          (state_q != ST_DOWN) && (state_q != ST_LOCK);
    end
  end

  // deserializer outputs: zero until valid data arrives
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pixel_data_out     <= '0;
      pixel_clock_out    <= 1'b0;
      vertical_sync      <= 1'b0;
      horizontal_sync    <= 1'b0;
      data_valid_strobe  <= 1'b0;
      parity_error_pulse <= 1'b0;
    end else if (clk_en) begin
      if (!pd_ok || role_ser || !running || !rx_data_valid) begin
        pixel_data_out     <= '0;
        pixel_clock_out    <= 1'b0;
        vertical_sync      <= 1'b0;
        horizontal_sync    <= 1'b0;
        data_valid_strobe  <= 1'b0;
        parity_error_pulse <= 1'b0;
      end else begin
        pixel_data_out     <= rx_pixel_data;
        pixel_clock_out    <= rx_pixel_clock;
        vertical_sync      <= rx_vsync;
        horizontal_sync    <= rx_hsync;
        data_valid_strobe  <= rx_de;
        parity_error_pulse <= rx_parity_err;
      end
    end
  end

  // checks
  a_pd_out_low: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && !pd_ok |=> !power_down_out_n)
    else $error("power-down output not low while down");
  a_cur_off: assert property (@(posedge ref_clk) disable iff (rst)
    !pd_ok |-> !lane_current_en)
    else $error("lane current on while down");
  // lock may drop in any driving state; the drive must follow it down
  a_drive_gate: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && link_drive_en && !pll_locked |=> !link_drive_en)
    else $error("link driven without lock");
  a_data_late: assert property (@(posedge ref_clk) disable iff (rst)
    data_transfer_ok |-> state_q == ST_RUN)
    else $error("data allowed before calibration");
  a_des_zero: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && !pd_ok |=> pixel_data_out == '0 && !vertical_sync)
    else $error("deserializer outputs not low in power-down");
  a_swap_role: assert property (@(posedge ref_clk) disable iff (rst)
    lane_swap == !role_ser)
    else $error("lane swap does not follow role");
  a_lock_loss: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && state_q == ST_COUNT && !pll_locked && pd_ok
    |=> state_q == ST_LOCK)
    else $error("lock loss not handled");
  a_down_hold: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && !pd_ok |=> state_q == ST_DOWN)
    else $error("left power-down with pin low");
  // only a serializer may release the remote device from power-down
  a_pdo_role: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && !role_ser |=> !power_down_out_n)
    else $error("power-down output high in deserializer role");
  // last counted rise after relock opens the link
  a_count_done: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && pd_ok && state_q == ST_COUNT && pll_locked && pclk_rise &&
    cnt_q == CW'(RELOCK_COUNT - 1) |=> state_q == ST_CAL)
    else $error("link not enabled after relock count");
  // drive may only start from the end of the relock count
  a_drive_rise: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(link_drive_en) |-> $past(state_q) == ST_COUNT)
    else $error("link drive started without relock count");
  // received words reach the panel pins one cycle later
  a_des_follow: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && pd_ok && !role_ser && running && rx_data_valid
    |=> pixel_data_out == $past(rx_pixel_data))
    else $error("received word not passed to outputs");
  // no pll in deserializer role
  a_pll_off: assert property (@(posedge ref_clk) disable iff (rst)
    !role_ser |-> !pll_enable)
    else $error("pll enabled in deserializer role");
  c_count_done: cover property (@(posedge ref_clk) disable iff (rst)
    state_q == ST_COUNT ##1 state_q == ST_CAL);
  c_ser_run: cover property (@(posedge ref_clk) disable iff (rst)
    role_ser && running);
  c_des_out: cover property (@(posedge ref_clk) disable iff (rst)
    !role_ser && data_valid_strobe);
  c_relock: cover property (@(posedge ref_clk) disable iff (rst)
    state_q == ST_RUN ##1 state_q == ST_LOCK);

endmodule

//--- verification/pixel_host_model.sv
// host model: pixel clock source and pll lock indication
module pixel_host_model (
  // clock and control from the bench
  input  wire logic ref_clk,
  input  wire logic run,
  // towards the sequencer
  output logic      pixel_clock_in,
  output logic      pll_locked
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] sync_q  = 2'h0; // pixel clock sampler
  logic [1:0] rises_q = 2'h0; // rises seen since lock was lost
  logic [4:0] idle_q  = 5'h00; // ref cycles since last rise
  // clean stop, held low
  // stopping only from a full half period avoids runt pulses
  initial begin
    pixel_clock_in = 1'b0;
    #37;
    forever begin
      #400;
      pixel_clock_in = run ? ~pixel_clock_in : 1'b0;
    end
  end
  always_ff @(posedge ref_clk) begin
    sync_q <= {sync_q[0], pixel_clock_in};
    if (sync_q == 2'h1) begin
      idle_q <= 5'h00;
      if (rises_q != 2'h3) rises_q <= rises_q + 2'h1;
    end else if (idle_q != 5'h14) begin
      idle_q <= idle_q + 5'h01;
    end else begin
      rises_q <= 2'h0;
    end
  end
  // lock after three rises, lost after twenty quiet cycles
  assign pll_locked = (rises_q == 2'h3) && (idle_q != 5'h14);
endmodule

//--- verification/tb_serdes_power_down_clock_stop.sv
// self-checking bench for the power-down and clock-stop sequencer
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin errors++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module tb_serdes_power_down_clock_stop;
  import pwr_seq_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned RC = 8; // shortened relock count
  logic        ref_clk, rst, pd_n, role, run, lock, pclk, rxv;
  logic        pdo, plle, six, drv, rcv, cur, swp, reo, dtok, poe;
  logic [22:0] rxw, outw, w; // {data, vs, hs, de, pe, pclk}
  logic [22:0] q[$];         // expected parallel words
  int          errors, compares, cycles;
  pixel_host_model host (.ref_clk(ref_clk), .run(run),
    .pixel_clock_in(pclk), .pll_locked(lock));
  serdes_power_down_clock_stop #(.RELOCK_COUNT(RC)) uut (
    .ref_clk(ref_clk), .rst(rst), .clk_en(1'b1), .power_down_n(pd_n),
    .serializer_role(role), .pixel_clock_in(pclk), .pll_locked(lock),
    .rx_data_valid(rxv), .rx_pixel_data(rxw[22:5]), .rx_vsync(rxw[4]),
    .rx_hsync(rxw[3]), .rx_de(rxw[2]), .rx_parity_err(rxw[1]),
    .rx_pixel_clock(rxw[0]), .power_down_out_n(pdo), .pll_enable(plle),
    .pll_mult_six(six), .link_drive_en(drv), .link_recv_en(rcv),
    .lane_current_en(cur), .lane_swap(swp), .parallel_reorder(reo),
    .data_transfer_ok(dtok), .pixel_data_out(outw[22:5]),
    .pixel_clock_out(outw[0]), .vertical_sync(outw[4]),
    .horizontal_sync(outw[3]), .data_valid_strobe(outw[2]),
    .parity_error_pulse(outw[1]), .parallel_out_en(poe));
  // free-running reference clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // hang guard, the whole run needs about five hundred cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 8000) begin
      errors++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // inputs move one ns after the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // wait n pixel rises, then let the synchronizer settle
  task automatic rises(input int n);
    repeat (n) @(posedge pclk);
    cyc(2);
  endtask
  task automatic wait_lock();
    for (int i = 0; i < 300 && lock !== 1'b1; i++) cyc(1);
  endtask
  task automatic start(input logic pd, input logic r);
    rst = 1'b1;
    pd_n = pd;
    role = r;
    cyc(5);
    rst = 1'b0;
    cyc(4);
  endtask
  // main sequence
  initial begin
    rst = 1'b1; pd_n = 1'b1; role = 1'b0; run = 1'b0; rxv = 1'b0;
    rxw = 23'h000000;
    void'($urandom(32'h4f131f85));
    rxw = 23'($urandom);
    start(1'b1, 1'b0);
    `CHK("idle word", 23'h000000, outw)
    `CHK("out enable", 1'b1, poe)
    `CHK("lane swap", 1'b1, swp)
    `CHK("reorder", 1'b1, reo)
    `CHK("recv en", 1'b1, rcv)
    `CHK("drive en", 1'b0, drv)
    `CHK("pll en", 1'b0, plle)
    // receive words pass one cycle later
    repeat (8) begin
      w = 23'($urandom);
      rxw = w;
      rxv = 1'b1;
      q.push_back(w);
      cyc(1);
      `CHK("par word", q.pop_front(), outw)
    end
    pd_n = 1'b0;
    cyc(5);
    `CHK("pd word", 23'h000000, outw)
    `CHK("lane cur", 1'b0, cur)
    // power-down held through reset keeps serializer down
    run = 1'b1;
    start(1'b0, 1'b1);
    cyc(60);
    `CHK("pd out", 1'b0, pdo)
    `CHK("lane cur", 1'b0, cur)
    pd_n = 1'b1;
    rxv = 1'b0;
    cyc(8);
    wait_lock();
    rises(6);
    `CHK("pd out", 1'b1, pdo)
    `CHK("mult six", 1'b1, six)
    `CHK("pll en", 1'b1, plle)
    `CHK("lane swap", 1'b0, swp)
    `CHK("drive en", 1'b0, drv)
    rises(4);
    `CHK("drive en", 1'b1, drv)
    `CHK("xfer ok", 1'b0, dtok)
    rises(12);
    `CHK("xfer ok", 1'b0, dtok)
    rises(6);
    `CHK("xfer ok", 1'b1, dtok)
    // clock stop, then restart and recount
    run = 1'b0;
    cyc(40);
    `CHK("pd out", 1'b0, pdo)
    `CHK("drive en", 1'b0, drv)
    run = 1'b1;
    wait_lock();
    rises(6);
    `CHK("drive en", 1'b0, drv)
    rises(4);
    `CHK("drive en", 1'b1, drv)
    pd_n = 1'b0;
    cyc(5);
    `CHK("pd out", 1'b0, pdo)
    `CHK("lane cur", 1'b0, cur)
    finish_test();
  end
endmodule
